// ### snz_cfg.svh
// snooze wake control: register offsets, field positions, reset values
// assumes a byte-addressed plain register port with byte offsets below
`ifndef SNZ_CFG_SVH
`define SNZ_CFG_SVH
`define SNZ_ADDR_W      5
`define SNZ_OFF_CTRL    5'h00
`define SNZ_OFF_UPPER   5'h04
`define SNZ_OFF_LOWER   5'h08
`define SNZ_OFF_ID      5'h0c
`define SNZ_OFF_STATUS  5'h10
`define SNZ_OFF_MASK    5'h14
`define SNZ_OFF_STATE   5'h18
// control fields
`define SNZ_CTL_ADC_EN  0
`define SNZ_CTL_UART_EN 1
`define SNZ_CTL_DTC_EN  2
`define SNZ_CTL_EXT_EN  3
`define SNZ_CTL_ACT_HI  4
`define SNZ_CTL_SEL_LO  5
`define SNZ_CTL_W       8
`define SNZ_CTL_RST     8'h10
// status and mask fields
`define SNZ_ST_ADC      0
`define SNZ_ST_RXID     1
`define SNZ_ST_EXT      2
`define SNZ_ST_RXBAD    3
`define SNZ_ST_W        4
`define SNZ_MASK_RST    4'h0
`endif

// ### snz_pin_drv.sv
// snooze status pin bank: one selected pin shows the snooze state
// assumes active and select come from the controller's own flops
`timescale 1ns/1ps
module snz_pin_drv #(
    parameter int NPINS = 8
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             active,
    input  wire logic [2:0]       sel,
    input  wire logic             act_high,
    output logic      [NPINS-1:0] pins
);
    initial begin
        if (NPINS < 1 || NPINS > 8) $error("pin count must be 1 to 8");
    end

    // each pin rests at the inactive level unless selected while snoozing
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pins[i] <= 1'b0;
            end else if (active && sel == 3'(i)) begin
                pins[i] <= act_high;
            end else begin
                pins[i] <= ~act_high;
            end
        end
    end

    pin_level_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 (pins[0] == ($past(active) && $past(sel) == 3'h0 ? $past(act_high)
                         : !$past(act_high))))
        else $error("status pin level wrong");
    pin_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        (!active && $stable(act_high)) |=> (pins == {NPINS{!$past(act_high)}}))
        else $error("status pin not idle");
endmodule : snz_pin_drv

// ### snz_pkg.sv
// snooze wake control: shared types
// assumes snz_cfg.svh supplies the numeric constants
package snz_pkg;
    // one-hot power states
    typedef enum logic [4:0] {
        ST_NORMAL   = 5'h01,
        ST_STOP     = 5'h02,
        ST_SNZ_ADC  = 5'h04,
        ST_SNZ_UART = 5'h08,
        ST_SNZ_DTC  = 5'h10
    } snz_state_type;
endpackage : snz_pkg

// ### snz_serial_tx.sv
// serial transmitter model for the far end of the receive line
// assumes the bench pulses go for one clock with the byte beside it
`timescale 1ns/1ps
module snz_serial_tx #(
    parameter int BIT_CYC = 4
) (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] tx_byte,
    output logic            line,
    output logic            done,
    output logic [7:0]      done_byte
);
    // bit time is shortened to keep runs brief; a real link near 4926 bps from a
    // 32 MHz clock uses prescaler 1/2, 16 samples per bit and divisor 203
    localparam int SAMPLES_PER_BIT = 16;
    localparam int BAUD_DIVISOR    = 203;

    // line idles high, like a pulled-up receive pin
    initial begin
        line = 1'b1;
        done = 1'b0;
        done_byte = 8'h00;
    end

    // frame: start low, eight data bits lsb first, parity, stop high
    always begin : frame_gen
        logic [10:0] frame;
        @(posedge clk);
        if (go) begin
            frame = {1'b1, ^tx_byte, tx_byte, 1'b0};
            for (int i = 0; i < 11; i++) begin
                line <= frame[i];
                repeat (BIT_CYC) @(posedge clk);
            end
            done_byte <= tx_byte;
            done      <= 1'b1;
            @(posedge clk);
            done      <= 1'b0;
            done_byte <= ~tx_byte; // stale byte is not left looking valid
        end
    end
endmodule : snz_serial_tx

// ### snz_wake_ctrl.sv
// snooze wake controller: stop/snooze/normal sequencing, wake decisions
// assumes converter, uart, dtc and timers sit outside; inputs are synchronous
//
// Contract
// - high range bit set for 64/48 MHz
// - snooze state shown on one of eight pins
// - status pin active level is configurable
// - timer event starts conversion while snoozing
// - result outside limits raises interrupt, wakes
// - result inside limits returns quietly to stop
// - receptions outside proper snooze flagged unreliable
// - any reset ends snooze at once
// - watchdog oscillator follows option byte setting; code follows it in snooze only and keeps it running in stop and normal
// - snooze entered only from stop
// - timer event triggers dtc without waking cpu
// - enabled pin interrupt in snooze wakes
// - receive edge in stop starts uart snooze
// - id match wakes with interrupt, else stop
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "snz_cfg.svh"
module snz_wake_ctrl #(
    parameter int ADC_W  = 10,
    parameter int NPINS  = 8
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // register port
    input  wire logic [`SNZ_ADDR_W-1:0] addr,
    input  wire logic [31:0]           wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [31:0]           rdata,
    // option byte straps
    input  wire logic                  opt_high_range,
    input  wire logic                  opt_wdt_osc_run,
    // cpu and peripheral events
    input  wire logic                  stop_req,
    input  wire logic                  conversion_trigger_timer,
    input  wire logic                  adc_done,
    input  wire logic [ADC_W-1:0]      adc_result,
    input  wire logic                  serial_receive_pin,
    input  wire logic                  rx_done,
    input  wire logic [7:0]            rx_byte,
    input  wire logic                  dtc_trigger_timer,
    input  wire logic                  dtc_done,
    input  wire logic                  external_pin_interrupt,
    // outputs
    output logic                       osc_run,
    output logic                       low_osc_run,
    output logic                       osc_high_range_select,
    output logic                       cpu_run,
    output logic                       adc_start,
    output logic                       rx_start,
    output logic                       dtc_req,
    output logic                       serial_receive_interrupt,
    output logic                       irq,
    output logic      [NPINS-1:0]      snooze_state_pin
);
    import snz_pkg::*;

    initial begin
        if (ADC_W < 1 || ADC_W > 16) $error("converter width must be 1 to 16");
    end

    snz_state_type                state_q, state_d;
    logic [`SNZ_CTL_W-1:0]        ctrl_q;
    logic [ADC_W-1:0]             upper_q, lower_q;
    logic [7:0]                   id_q;
    logic [`SNZ_ST_W-1:0]         status_q, mask_q, set_st;
    logic                         rx_prev_q, opt_done_q, opt_wdt_q;
    logic                         rx_edge, ext_ev, adc_out, id_hit;

    function automatic logic is_snz(input snz_state_type s);
        return s == ST_SNZ_ADC || s == ST_SNZ_UART || s == ST_SNZ_DTC;
    endfunction : is_snz

    function automatic logic out_of_window(input logic [ADC_W-1:0] v,
                                           input logic [ADC_W-1:0] lo,
                                           input logic [ADC_W-1:0] hi);
        return (v < lo) || (v > hi);
    endfunction : out_of_window

    // event decode shared by the state machine and the flags
    assign rx_edge = rx_prev_q && !serial_receive_pin; // start bit edge
    assign ext_ev  = external_pin_interrupt && ctrl_q[`SNZ_CTL_EXT_EN];
    assign adc_out = out_of_window(adc_result, lower_q, upper_q);
    assign id_hit  = (rx_byte == id_q);

    // next power state; pin interrupt has top priority so a wake is never lost
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_NORMAL: begin
                if (stop_req) state_d = ST_STOP;
            end
            ST_STOP: begin
                if (ext_ev) begin
                    state_d = ST_NORMAL;
                end else if (conversion_trigger_timer && ctrl_q[`SNZ_CTL_ADC_EN]) begin
                    state_d = ST_SNZ_ADC;
                end else if (rx_edge && ctrl_q[`SNZ_CTL_UART_EN]) begin
                    state_d = ST_SNZ_UART;
                end else if (dtc_trigger_timer && ctrl_q[`SNZ_CTL_DTC_EN]) begin
                    state_d = ST_SNZ_DTC;
                end
            end
            ST_SNZ_ADC: begin
                if (ext_ev) begin
                    state_d = ST_NORMAL;
                end else if (adc_done) begin
                    state_d = adc_out ? ST_NORMAL : ST_STOP;
                end
            end
            ST_SNZ_UART: begin
                if (ext_ev) begin
                    state_d = ST_NORMAL;
                end else if (rx_done) begin
                    state_d = id_hit ? ST_NORMAL : ST_STOP;
                end
            end
            ST_SNZ_DTC: begin
                if (ext_ev) begin
                    state_d = ST_NORMAL;
                end else if (dtc_done) begin
                    state_d = ST_STOP;
                end
            end
            default: state_d = ST_NORMAL;
        endcase
    end

    // state register; reset drops any snooze straight to normal
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // receive line history; idle line is high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= serial_receive_pin;
        end
    end

    // option straps are caught once, the first cycle after reset release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opt_done_q            <= 1'b0;
            opt_wdt_q             <= 1'b0;
            osc_high_range_select <= 1'b0;
        end else if (!opt_done_q) begin
            opt_done_q            <= 1'b1;
            opt_wdt_q             <= opt_wdt_osc_run;
            osc_high_range_select <= opt_high_range;
        end
    end

    // clock and cpu controls follow the next state so they align with it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_run     <= 1'b1;
            low_osc_run <= 1'b1;
            cpu_run     <= 1'b1;
        end else begin
            osc_run     <= (state_d != ST_STOP);
            low_osc_run <= is_snz(state_d) ? opt_wdt_q : 1'b1;
            cpu_run     <= (state_d == ST_NORMAL);
        end
    end

    // one-cycle starts for the peripheral that serves this snooze
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adc_start <= 1'b0;
            rx_start  <= 1'b0;
            dtc_req   <= 1'b0;
        end else begin
            adc_start <= (state_q == ST_STOP) && (state_d == ST_SNZ_ADC);
            rx_start  <= (state_q == ST_STOP) && (state_d == ST_SNZ_UART);
            dtc_req   <= (state_q == ST_STOP) && (state_d == ST_SNZ_DTC);
        end
    end

    // serial receive interrupt pulses only on an id match in snooze
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_receive_interrupt <= 1'b0;
        end else begin
            serial_receive_interrupt <= set_st[`SNZ_ST_RXID];
        end
    end

    // event flags; a reception outside a clean uart snooze cannot be trusted
    always_comb begin
        set_st = '0;
        set_st[`SNZ_ST_ADC]   = (state_q == ST_SNZ_ADC) && !ext_ev && adc_done
                                && adc_out;
        set_st[`SNZ_ST_RXID]  = (state_q == ST_SNZ_UART) && !ext_ev && rx_done
                                && id_hit;
        set_st[`SNZ_ST_EXT]   = ext_ev && (state_q != ST_NORMAL);
        set_st[`SNZ_ST_RXBAD] = ctrl_q[`SNZ_CTL_UART_EN] && rx_edge
                                && (state_q == ST_NORMAL || state_q == ST_SNZ_ADC
                                    || state_q == ST_SNZ_DTC);
    end

    // register writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q  <= `SNZ_CTL_RST;
            upper_q <= '1;
            lower_q <= '0;
            id_q    <= 8'h00;
            mask_q  <= `SNZ_MASK_RST;
        end else if (wr) begin
            case (addr)
                `SNZ_OFF_CTRL:  ctrl_q  <= wdata[`SNZ_CTL_W-1:0];
                `SNZ_OFF_UPPER: upper_q <= wdata[ADC_W-1:0];
                `SNZ_OFF_LOWER: lower_q <= wdata[ADC_W-1:0];
                `SNZ_OFF_ID:    id_q    <= wdata[7:0];
                `SNZ_OFF_MASK:  mask_q  <= wdata[`SNZ_ST_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky status, cleared by a read; a same-cycle event still sets
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= '0;
        end else if (rd && addr == `SNZ_OFF_STATUS) begin
            status_q <= set_st;
        end else begin
            status_q <= status_q | set_st;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // read data stand for the single cycle after the strobe; unmapped read zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0;
        end else if (rd) begin
            case (addr)
                `SNZ_OFF_CTRL:   rdata <= 32'(ctrl_q);
                `SNZ_OFF_UPPER:  rdata <= 32'(upper_q);
                `SNZ_OFF_LOWER:  rdata <= 32'(lower_q);
                `SNZ_OFF_ID:     rdata <= 32'(id_q);
                `SNZ_OFF_STATUS: rdata <= 32'(status_q);
                `SNZ_OFF_MASK:   rdata <= 32'(mask_q);
                `SNZ_OFF_STATE:  rdata <= 32'({osc_high_range_select, state_q});
                default:         rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // status pin bank
    snz_pin_drv #(
        .NPINS (NPINS)
    ) u_pins (
        .clk      (clk),
        .rstn     (rstn),
        .active   (is_snz(state_q)),
        .sel      (ctrl_q[`SNZ_CTL_SEL_LO +: 3]),
        .act_high (ctrl_q[`SNZ_CTL_ACT_HI]),
        .pins     (snooze_state_pin)
    );

    snz_entry_a: assert property (@(posedge clk) disable iff (!rstn)
        (is_snz(state_q) && !$past(is_snz(state_q))) |-> $past(state_q) == ST_STOP)
        else $error("snooze entered from wrong state");
    adc_wake_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == ST_SNZ_ADC && adc_done && adc_out && !ext_ev)
        |=> state_q == ST_NORMAL && status_q[`SNZ_ST_ADC])
        else $error("out of window result did not wake");
    adc_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == ST_SNZ_ADC && adc_done && !adc_out && !ext_ev)
        |=> state_q == ST_STOP && !cpu_run)
        else $error("in window result did not return to stop");
    id_check_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == ST_SNZ_UART && rx_done && !ext_ev)
        |=> (serial_receive_interrupt ? state_q == ST_NORMAL : state_q == ST_STOP)
            && serial_receive_interrupt == $past(id_hit))
        else $error("id compare outcome wrong");
    pin_wake_a: assert property (@(posedge clk) disable iff (!rstn)
        (is_snz(state_q) && ext_ev) |=> state_q == ST_NORMAL ##0 cpu_run)
        else $error("pin interrupt did not wake");
    rx_enter_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == ST_STOP && !ext_ev && !(conversion_trigger_timer
         && ctrl_q[`SNZ_CTL_ADC_EN]) && rx_edge && ctrl_q[`SNZ_CTL_UART_EN])
        |=> state_q == ST_SNZ_UART && rx_start && osc_run ##1 !rx_start)
        else $error("receive edge did not start uart snooze");
    wdt_osc_a: assert property (@(posedge clk) disable iff (!rstn)
        is_snz(state_q) |-> low_osc_run == opt_wdt_q)
        else $error("watchdog oscillator ignores option");
    dtc_run_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == ST_SNZ_DTC && !ext_ev && !dtc_done) |=> !cpu_run)
        else $error("cpu woken by dtc snooze");
    rx_unsafe_a: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl_q[`SNZ_CTL_UART_EN] && rx_edge && state_q == ST_NORMAL)
        |=> status_q[`SNZ_ST_RXBAD])
        else $error("unreliable reception not flagged");
endmodule : snz_wake_ctrl

// ### snz_wake_ctrl_bench.sv
// self-checking bench for the snooze wake controller
// assumes a 200 MHz clock and a serial transmitter model on the receive pin
`timescale 1ns/1ps
`include "snz_cfg.svh"
module snz_wake_ctrl_bench;
    logic        clk, rstn, wr, rd, opt_high_range, opt_wdt_osc_run, stop_req;
    logic        conv_trig, adc_done, rx_pin, rx_done, dtc_trig, dtc_done, ext_int;
    logic        osc_run, low_osc_run, hr_sel, cpu_run, adc_start, rx_start, dtc_req;
    logic        rx_irq, irq, tx_go;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic [9:0]  adc_result;
    logic [7:0]  rx_byte, tx_byte, pins;
    int          n_fail, cmp_count;
    logic [9:0]  res[5]  = '{10'h050, 10'h180, 10'h100, 10'h200, 10'h201};
    logic        wake[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

    snz_wake_ctrl snz_wake_ctrl_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .opt_high_range(opt_high_range),
        .opt_wdt_osc_run(opt_wdt_osc_run), .stop_req(stop_req),
        .conversion_trigger_timer(conv_trig), .adc_done(adc_done),
        .adc_result(adc_result), .serial_receive_pin(rx_pin), .rx_done(rx_done),
        .rx_byte(rx_byte), .dtc_trigger_timer(dtc_trig), .dtc_done(dtc_done),
        .external_pin_interrupt(ext_int), .osc_run(osc_run), .low_osc_run(low_osc_run),
        .osc_high_range_select(hr_sel), .cpu_run(cpu_run), .adc_start(adc_start),
        .rx_start(rx_start), .dtc_req(dtc_req), .serial_receive_interrupt(rx_irq),
        .irq(irq), .snooze_state_pin(pins));
    snz_serial_tx snz_serial_tx_i (.clk(clk), .go(tx_go), .tx_byte(tx_byte),
        .line(rx_pin), .done(rx_done), .done_byte(rx_byte));

    // free-running clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // one-cycle event: 0 stop, 1 conv trig, 2 dtc trig, 3 ext pin, 4 dtc done, 5 adc done
    task automatic ev(input int k);
        @(posedge clk);
        case (k)
            0: stop_req <= 1'b1;
            1: conv_trig <= 1'b1;
            2: dtc_trig <= 1'b1;
            3: ext_int <= 1'b1;
            4: dtc_done <= 1'b1;
            default: adc_done <= 1'b1;
        endcase
        @(posedge clk);
        {stop_req, conv_trig, dtc_trig, ext_int, dtc_done, adc_done} <= 6'h00;
    endtask : ev

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    function automatic logic probe(input int k);
        case (k)
            0: probe = rx_start;
            1: probe = ~osc_run;
            2: probe = rx_irq;
            default: probe = rx_done;
        endcase
    endfunction : probe

    // bounded wait on an observable; running out counts as a mismatch
    task automatic waitp(input int k);
        int i;
        i = 0;
        while (probe(k) !== 1'b1 && i < 200) begin
            step();
            i++;
        end
        chk("wait", {31'h0, i < 200}, 32'h1);
    endtask : waitp

    task automatic send(input logic [7:0] b);
        @(posedge clk);
        tx_go <= 1'b1;
        tx_byte <= b;
        @(posedge clk);
        tx_go <= 1'b0;
    endtask : send

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    // main sequence
    initial begin
        {rstn, wr, rd, stop_req, conv_trig, adc_done, dtc_trig, dtc_done, ext_int} = 9'h0;
        {addr, wdata, adc_result, tx_go, tx_byte} = '0;
        opt_high_range = 1'b1;
        opt_wdt_osc_run = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) step();
        chk("range_sel", hr_sel, 1);
        chk("pins", pins, 0);
        rd_reg(`SNZ_OFF_CTRL, d);
        chk("ctrl", d, 32'h10);
        rd_reg(`SNZ_OFF_UPPER, d);
        chk("upper", d, 32'h3ff);
        rd_reg(`SNZ_OFF_STATE, d);
        chk("state", d, 32'h21);
        rd_reg(5'h1c, d);
        chk("unmapped", d, 0);
        wr_reg(`SNZ_OFF_UPPER, 32'h200);
        wr_reg(`SNZ_OFF_LOWER, 32'h100);
        wr_reg(`SNZ_OFF_MASK, 32'hf);
        wr_reg(`SNZ_OFF_ID, 32'h5a);
        // all snooze enables set before stop, active high, pin 3 selected
        wr_reg(`SNZ_OFF_CTRL, 32'h7f);
        ev(1);
        step();
        chk("adc_start", adc_start, 0);
        // window compare table, limits inclusive
        for (int i = 0; i < 5; i++) begin
            if (cpu_run === 1'b1)
                ev(0);
            step();
            chk("cpu_stop", {osc_run, cpu_run}, 0);
            @(posedge clk);
            adc_result <= res[i];
            ev(1);
            #1; // the start pulse stands only in the cycle after entry
            chk("adc_start", {adc_start, osc_run, low_osc_run}, 3'b110);
            step();
            chk("pins", pins, 8'h08);
            ev(5);
            step();
            chk("cpu_run", cpu_run, wake[i]);
            step();
            chk("pins_off", pins, 0);
            chk("irq", irq, wake[i]);
            rd_reg(`SNZ_OFF_STATUS, d);
            chk("status", d, {31'h0, wake[i]});
        end
        send(8'h11);
        waitp(3);
        step();
        rd_reg(`SNZ_OFF_STATUS, d);
        chk("status", d, 32'h8);
        ev(0);
        send(8'h33);
        waitp(0);
        waitp(3);
        waitp(1);
        rd_reg(`SNZ_OFF_STATE, d);
        chk("state", d, 32'h22);
        send(8'h5a);
        waitp(2);
        step();
        chk("cpu_run", cpu_run, 1);
        rd_reg(`SNZ_OFF_STATUS, d);
        chk("status", d, 32'h2);
        ev(0);
        ev(2);
        #1; // request pulse stands only in the cycle after entry
        chk("dtc_req", {dtc_req, cpu_run}, 2'b10);
        ev(4);
        waitp(1);
        ev(2);
        ev(3);
        step();
        chk("cpu_run", cpu_run, 1);
        rd_reg(`SNZ_OFF_STATUS, d);
        chk("status", d, 32'h4);
        // active low: selected pin idles high
        wr_reg(`SNZ_OFF_CTRL, 32'h6f);
        repeat (2) step();
        chk("pin_low", pins[3], 1);
        ev(0);
        ev(1);
        repeat (2) step();
        chk("pin_low", pins[3], 0);
        @(posedge clk);
        rstn <= 1'b0;
        #1;
        chk("reset", {cpu_run, pins}, 9'h100);
        wrap_up();
    end
endmodule : snz_wake_ctrl_bench
